//--- alu_pkg.sv
package alu_pkg;

    // ==========================================================
    // Register map (byte addresses, one aligned word each)
    localparam logic [7:0] OFS_INSTR    = 8'h00;
    localparam logic [7:0] OFS_FLAGS    = 8'h04;
    localparam logic [7:0] OFS_STATUS   = 8'h08;
    localparam logic [7:0] OFS_RF_INDEX = 8'h0c;
    localparam logic [7:0] OFS_RF_DATA  = 8'h10;
    localparam logic [7:0] OFS_RESULT   = 8'h14;

    // ==========================================================
    // Instruction word fields
    localparam int OPC_HI  = 31;
    localparam int OPC_LO  = 26;
    localparam int ZW_BIT  = 25;
    localparam int CW_BIT  = 24;
    localparam int RW_BIT  = 23;
    localparam int IMM_BIT = 22;
    localparam int DST_HI  = 17;
    localparam int DST_LO  = 9;
    localparam int SRC_HI  = 8;
    localparam int SRC_LO  = 0;

    localparam int DATA_W = 32;
    localparam int RADR_W = 9;
    localparam int RF_DEPTH = 512;

    // ==========================================================
    // Opcodes
    localparam logic [5:0] OPC_NEGATE_ABSOLUTE         = 6'h2b;
    localparam logic [5:0] OPC_UNSIGNED_SUM            = 6'h20;
    localparam logic [5:0] OPC_SUM_WITH_MAGNITUDE      = 6'h22;
    localparam logic [5:0] OPC_SIGNED_SUM              = 6'h34;
    localparam logic [5:0] OPC_SIGNED_SUM_WITH_CARRY   = 6'h36;
    localparam logic [5:0] OPC_UNSIGNED_SUM_WITH_CARRY = 6'h32;

    // ==========================================================
    // Flag and status bits, reset values
    localparam int FLAG_Z_BIT     = 0;
    localparam int FLAG_C_BIT     = 1;
    localparam int STAT_BUSY_BIT  = 0;
    localparam int STAT_BADOP_BIT = 1;
    localparam logic        FLAG_RST   = 1'b0;
    localparam logic [31:0] WORD_RST   = 32'h0000_0000;
    localparam logic [8:0]  INDEX_RST  = 9'h000;

    // ==========================================================
    // Timing and bus answers
    localparam int         EXEC_CYCLES = 4;
    localparam logic [1:0] EXEC_LAST   = 2'(EXEC_CYCLES - 1);
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h1,
        ST_EXEC = 2'h2
    } exec_state_t;

endpackage

//--- cog_add_abs_alu.sv
// Chosen here: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
module cog_add_abs_alu
    import alu_pkg::*;
(
    input  wire logic        sys_clk_i,
    input  wire logic        rst_i,
    input  wire logic [7:0]  s_axi_awaddr_i,
    input  wire logic        s_axi_awvalid_i,
    output logic             s_axi_awready_o,
    input  wire logic [31:0] s_axi_wdata_i,
    input  wire logic [3:0]  s_axi_wstrb_i,
    input  wire logic        s_axi_wvalid_i,
    output logic             s_axi_wready_o,
    output logic [1:0]       s_axi_bresp_o,
    output logic             s_axi_bvalid_o,
    input  wire logic        s_axi_bready_i,
    input  wire logic [7:0]  s_axi_araddr_i,
    input  wire logic        s_axi_arvalid_i,
    output logic             s_axi_arready_o,
    output logic [31:0]      s_axi_rdata_o,
    output logic [1:0]       s_axi_rresp_o,
    output logic             s_axi_rvalid_o,
    input  wire logic        s_axi_rready_i,
    output logic             busy_o,
    output logic             zero_flag_o,
    output logic             carry_flag_o
);

    // ==========================================================
    // State
    typedef struct packed {
        exec_state_t  state;
        logic [1:0]   cnt;
        logic [31:0]  instr;
        logic         zflag;
        logic         cflag;
        logic         badop;
        logic [8:0]   rf_index;
        logic [31:0]  result;
        logic         aw_full;
        logic [7:0]   aw_addr;
        logic         w_full;
        logic [31:0]  wdata;
        logic [3:0]   wstrb;
        logic         awready;
        logic         wready;
        logic         bvalid;
        logic [1:0]   bresp;
        logic         arready;
        logic         rvalid;
        logic [1:0]   rresp;
        logic [31:0]  rdata;
    } alu_state_t;

    alu_state_t   st_reg;
    alu_state_t   st_next;
    // Register file has no reset: software must load operands first
    logic [31:0]  rf_mem [0:RF_DEPTH-1];
    logic         mem_we;
    logic [8:0]   mem_addr;
    logic [31:0]  mem_wdata;
    logic [31:0]  op_d;
    logic [31:0]  op_s;
    logic [32:0]  sum;
    logic [31:0]  res;
    logic         z_new;
    logic         c_new;
    logic         busy;
    logic         stall_wr;

    // ==========================================================
    // Helpers
    function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                          input logic [3:0] strb);
        logic [31:0] v;
        v = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                v[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return v;
    endfunction

    function automatic logic [31:0] magnitude(input logic [31:0] v);
        return v[31] ? 32'(-v) : v;
    endfunction

    function automatic logic supported(input logic [5:0] opc);
        return opc == OPC_NEGATE_ABSOLUTE || opc == OPC_UNSIGNED_SUM || opc == OPC_SUM_WITH_MAGNITUDE
            || opc == OPC_SIGNED_SUM || opc == OPC_SIGNED_SUM_WITH_CARRY
            || opc == OPC_UNSIGNED_SUM_WITH_CARRY;
    endfunction

    function automatic logic signed_ovf(input logic [31:0] a, input logic [31:0] b, input logic [31:0] r);
        return (a[31] == b[31]) && (r[31] != a[31]);
    endfunction

    // ==========================================================
    // Next state
    always_comb begin
        st_next   = st_reg;
        mem_we    = 1'b0;
        mem_addr  = st_reg.rf_index;
        mem_wdata = WORD_RST;
        busy      = (st_reg.state == ST_EXEC);
        op_d      = rf_mem[st_reg.instr[DST_HI:DST_LO]];
        op_s      = st_reg.instr[IMM_BIT] ? {23'h0, st_reg.instr[SRC_HI:SRC_LO]}
                                          : rf_mem[st_reg.instr[SRC_HI:SRC_LO]];
        sum       = 33'h0;
        res       = WORD_RST;
        z_new     = 1'b0;
        c_new     = 1'b0;

        // 33-bit sums keep the carry; the stored word wraps at 32 bits
        case (st_reg.instr[OPC_HI:OPC_LO])
            OPC_NEGATE_ABSOLUTE: begin
                res   = 32'(-magnitude(op_s));
                z_new = (op_s == WORD_RST);
                c_new = op_s[31];
            end
            OPC_UNSIGNED_SUM: begin
                sum   = {1'b0, op_d} + {1'b0, op_s};
                res   = sum[31:0];
                z_new = (res == WORD_RST);
                c_new = sum[32];
            end
            OPC_SUM_WITH_MAGNITUDE: begin
                sum   = {1'b0, op_d} + {1'b0, magnitude(op_s)};
                res   = sum[31:0];
                z_new = (res == WORD_RST);
                c_new = sum[32];
            end
            OPC_SIGNED_SUM: begin
                sum   = {1'b0, op_d} + {1'b0, op_s};
                res   = sum[31:0];
                z_new = (res == WORD_RST);
                c_new = signed_ovf(op_d, op_s, res);
            end
            OPC_SIGNED_SUM_WITH_CARRY: begin
                sum   = {1'b0, op_d} + {1'b0, op_s} + {32'h0, st_reg.cflag};
                res   = sum[31:0];
                z_new = st_reg.zflag & (res == WORD_RST);
                c_new = signed_ovf(op_d, op_s, res);
            end
            OPC_UNSIGNED_SUM_WITH_CARRY: begin
                sum   = {1'b0, op_d} + {1'b0, op_s} + {32'h0, st_reg.cflag};
                res   = sum[31:0];
                z_new = st_reg.zflag & (res == WORD_RST);
                c_new = sum[32];
            end
            default: begin
                res = WORD_RST;
            end
        endcase

        // ======================================================
        // Execution sequencer
        unique case (st_reg.state)
            ST_IDLE: begin
                st_next.cnt = 2'h0;
            end
            ST_EXEC: begin
                st_next.cnt = st_reg.cnt + 2'h1;
                if (st_reg.cnt == EXEC_LAST) begin
                    st_next.state  = ST_IDLE;
                    st_next.cnt    = 2'h0;
                    st_next.result = res;
                    if (st_reg.instr[ZW_BIT]) begin
                        st_next.zflag = z_new;
                    end
                    if (st_reg.instr[CW_BIT]) begin
                        st_next.cflag = c_new;
                    end
                    if (st_reg.instr[RW_BIT]) begin
                        mem_we    = 1'b1;
                        mem_addr  = st_reg.instr[DST_HI:DST_LO];
                        mem_wdata = res;
                    end
                end
            end
            default: begin
                st_next.state = ST_IDLE;
                st_next.cnt   = 2'h0;
            end
        endcase

        // ======================================================
        // Read channel
        if (st_reg.rvalid && s_axi_rready_i) begin
            st_next.rvalid = 1'b0;
        end
        if (s_axi_arvalid_i && st_reg.arready) begin
            st_next.rvalid = 1'b1;
            st_next.rresp  = RESP_OKAY;
            st_next.rdata  = WORD_RST;
            case ({s_axi_araddr_i[7:2], 2'b00})
                OFS_INSTR:    st_next.rdata = st_reg.instr;
                OFS_FLAGS:    st_next.rdata = {30'h0, st_reg.cflag, st_reg.zflag};
                OFS_STATUS:   st_next.rdata = {30'h0, st_reg.badop, busy};
                OFS_RF_INDEX: st_next.rdata = {23'h0, st_reg.rf_index};
                OFS_RF_DATA:  st_next.rdata = rf_mem[st_reg.rf_index];
                OFS_RESULT:   st_next.rdata = st_reg.result;
                default:      st_next.rresp = RESP_SLVERR;
            endcase
        end

        // ======================================================
        // Write channels: address and data are caught in either order
        if (s_axi_awvalid_i && st_reg.awready) begin
            st_next.aw_full = 1'b1;
            st_next.aw_addr = {s_axi_awaddr_i[7:2], 2'b00};
        end
        if (s_axi_wvalid_i && st_reg.wready) begin
            st_next.w_full = 1'b1;
            st_next.wdata  = s_axi_wdata_i;
            st_next.wstrb  = s_axi_wstrb_i;
        end
        if (st_reg.bvalid && s_axi_bready_i) begin
            st_next.bvalid = 1'b0;
        end

        // Writes that would disturb a running instruction wait for it to end
        stall_wr = busy && (st_reg.aw_addr == OFS_INSTR || st_reg.aw_addr == OFS_FLAGS
                            || st_reg.aw_addr == OFS_RF_DATA);
        if (st_reg.aw_full && st_reg.w_full && !st_reg.bvalid && !stall_wr) begin
            st_next.aw_full = 1'b0;
            st_next.w_full  = 1'b0;
            st_next.bvalid  = 1'b1;
            st_next.bresp   = RESP_OKAY;
            case (st_reg.aw_addr)
                OFS_INSTR: begin
                    st_next.instr = merge(st_reg.instr, st_reg.wdata, st_reg.wstrb);
                    if (supported(st_next.instr[OPC_HI:OPC_LO])) begin
                        st_next.state = ST_EXEC;
                        st_next.cnt   = 2'h0;
                    end else begin
                        st_next.badop = 1'b1;
                    end
                end
                OFS_FLAGS: begin
                    if (st_reg.wstrb[0]) begin
                        st_next.zflag = st_reg.wdata[FLAG_Z_BIT];
                        st_next.cflag = st_reg.wdata[FLAG_C_BIT];
                    end
                end
                OFS_STATUS: begin
                    if (st_reg.wstrb[0] && st_reg.wdata[STAT_BADOP_BIT]) begin
                        st_next.badop = 1'b0;
                    end
                end
                OFS_RF_INDEX: begin
                    st_next.rf_index = RADR_W'(merge({23'h0, st_reg.rf_index}, st_reg.wdata,
                                                     st_reg.wstrb));
                end
                OFS_RF_DATA: begin
                    mem_we    = 1'b1;
                    mem_addr  = st_reg.rf_index;
                    mem_wdata = merge(rf_mem[st_reg.rf_index], st_reg.wdata, st_reg.wstrb);
                end
                OFS_RESULT: begin
                    st_next.bresp = RESP_OKAY;
                end
                default: begin
                    st_next.bresp = RESP_SLVERR;
                end
            endcase
        end

        st_next.arready = !st_next.rvalid;
        st_next.awready = !st_next.aw_full && !st_next.bvalid;
        st_next.wready  = !st_next.w_full && !st_next.bvalid;
    end

    // ==========================================================
    // Registers
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_reg          <= '0;
            st_reg.state    <= ST_IDLE;
            st_reg.instr    <= WORD_RST;
            st_reg.zflag    <= FLAG_RST;
            st_reg.cflag    <= FLAG_RST;
            st_reg.rf_index <= INDEX_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (mem_we) begin
            rf_mem[mem_addr] <= mem_wdata;
        end
    end

    // ==========================================================
    // Outputs
    assign s_axi_awready_o = st_reg.awready;
    assign s_axi_wready_o  = st_reg.wready;
    assign s_axi_bvalid_o  = st_reg.bvalid;
    assign s_axi_bresp_o   = st_reg.bresp;
    assign s_axi_arready_o = st_reg.arready;
    assign s_axi_rvalid_o  = st_reg.rvalid;
    assign s_axi_rresp_o   = st_reg.rresp;
    assign s_axi_rdata_o   = st_reg.rdata;
    assign busy_o          = st_reg.state[1];
    assign zero_flag_o     = st_reg.zflag;
    assign carry_flag_o    = st_reg.cflag;

endmodule

//--- cog_add_abs_alu_asserts.sv
`timescale 1ns/1ps
module cog_add_abs_alu_asserts
    import alu_pkg::*;
(
    input wire logic        sys_clk_i,
    input wire logic        rst_i,
    input wire logic        s_axi_awready_o,
    input wire logic [1:0]  s_axi_bresp_o,
    input wire logic        s_axi_bvalid_o,
    input wire logic        s_axi_bready_i,
    input wire logic [7:0]  s_axi_araddr_i,
    input wire logic        s_axi_arvalid_i,
    input wire logic        s_axi_arready_o,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic [1:0]  s_axi_rresp_o,
    input wire logic        s_axi_rvalid_o,
    input wire logic        s_axi_rready_i,
    input wire logic        busy_o,
    input wire logic        zero_flag_o,
    input wire logic        carry_flag_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    // ==========================================================
    // Execution
    property p_busy_len; $rose(busy_o) |-> busy_o[*4] ##1 !busy_o; endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy not four cycles");
    property p_flag_hold; busy_o && $past(busy_o) |-> $stable({zero_flag_o, carry_flag_o}); endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flags moved mid execution");
    // Flags move only at the end of execution or on a bus write
    property p_flag_cause; !$stable({zero_flag_o, carry_flag_o}) |-> $fell(busy_o) or ##[0:2] s_axi_bvalid_o; endproperty
    a_flag_cause: assert property (p_flag_cause) else $error("flags moved without cause");
    // ==========================================================
    // Register bus
    property p_b_hold; s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o); endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped");
    property p_aw_block; s_axi_bvalid_o |-> !s_axi_awready_o; endproperty
    a_aw_block: assert property (p_aw_block) else $error("address taken during response");
    property p_r_hold; s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o); endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data dropped");
    property p_r_answer; s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o && !s_axi_arready_o; endproperty
    a_r_answer: assert property (p_r_answer) else $error("read answer late");
    property p_r_unmap;
        s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i > 8'h17 |=> s_axi_rresp_o == RESP_SLVERR;
    endproperty
    a_r_unmap: assert property (p_r_unmap) else $error("unmapped read not refused");
endmodule

//--- cog_add_abs_alu_bench.sv
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin error_cnt++; $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module cog_add_abs_alu_bench;
    import alu_pkg::*;
    logic        sys_clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [7:0]  s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
    logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o;
    logic [3:0]  s_axi_wstrb_i = 4'hf;
    logic        s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
    logic        s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
    logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
    logic [1:0]  s_axi_bresp_o, s_axi_rresp_o;
    logic        busy_o, zero_flag_o, carry_flag_o;
    int          error_cnt = 0;
    int          n_tests = 0;
    int          busy_cnt = 0;
    logic [31:0] seed = 32'he50858ad;
    logic [31:0] rf_m [RF_DEPTH];
    logic        z_m, c_m;
    logic [31:0] res_m = WORD_RST;
    logic [5:0]  ops [6] = '{OPC_NEGATE_ABSOLUTE, OPC_UNSIGNED_SUM, OPC_SUM_WITH_MAGNITUDE, OPC_SIGNED_SUM,
                             OPC_SIGNED_SUM_WITH_CARRY, OPC_UNSIGNED_SUM_WITH_CARRY};
    logic [31:0] spec [4] = '{32'h0, 32'h8000_0000, 32'hffff_ffff, 32'h7fff_ffff};

    cog_add_abs_alu i_cog_add_abs_alu (.sys_clk_i, .rst_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o,
        .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o,
        .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o,
        .s_axi_rvalid_o, .s_axi_rready_i, .busy_o, .zero_flag_o, .carry_flag_o);

    always #12.5 sys_clk_i = ~sys_clk_i;

    // Counts every edge at which the block reports itself busy
    always @(posedge sys_clk_i) begin
        if (busy_o === 1'b1) busy_cnt++;
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // ==========================================================
    // Bus tasks; response ready may come late to exercise holding
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic [31:0] q;
        s_axi_awaddr_i  <= a;
        s_axi_wdata_i   <= d;
        s_axi_awvalid_i <= 1'b1;
        s_axi_wvalid_i  <= 1'b1;
        forever begin
            @(posedge sys_clk_i);
            if (s_axi_awvalid_i && s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
            if (s_axi_wvalid_i && s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
            if (s_axi_bvalid_o && s_axi_bready_i) break;
            q = rnd();
            s_axi_bready_i <= s_axi_bready_i | q[4];
        end
        r = s_axi_bresp_o;
        s_axi_bready_i <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic [31:0] q;
        s_axi_araddr_i  <= a;
        s_axi_arvalid_i <= 1'b1;
        forever begin
            @(posedge sys_clk_i);
            if (s_axi_arvalid_i && s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
            if (s_axi_rvalid_o && s_axi_rready_i) break;
            q = rnd();
            s_axi_rready_i <= s_axi_rready_i | q[5];
        end
        d = s_axi_rdata_o;
        r = s_axi_rresp_o;
        s_axi_rready_i <= 1'b0;
    endtask

    task automatic put(input logic [8:0] idx, input logic [31:0] val);
        logic [1:0] rs;
        wr(OFS_RF_INDEX, 32'(idx), rs);
        wr(OFS_RF_DATA, val, rs);
        rf_m[idx] = val;
    endtask

    // ==========================================================
    // Reference model of one instruction
    task automatic model(input logic [31:0] ins);
        logic [31:0] d, s, a, r;
        logic        zz, cc;
        logic [5:0]  op;
        op = ins[OPC_HI:OPC_LO];
        d = rf_m[ins[DST_HI:DST_LO]];
        s = ins[IMM_BIT] ? 32'(ins[SRC_HI:SRC_LO]) : rf_m[ins[SRC_HI:SRC_LO]];
        a = s[31] ? -s : s;
        case (op)
            OPC_NEGATE_ABSOLUTE: begin r = -a; cc = s[31]; end
            OPC_UNSIGNED_SUM: {cc, r} = {1'b0, d} + {1'b0, s};
            OPC_SUM_WITH_MAGNITUDE: {cc, r} = {1'b0, d} + {1'b0, a};
            OPC_UNSIGNED_SUM_WITH_CARRY: {cc, r} = {1'b0, d} + {1'b0, s} + 33'(c_m);
            default: begin r = d + s + 32'(op[1] & c_m); cc = d[31] == s[31] && r[31] != d[31]; end
        endcase
        zz = r == 32'h0 && (op inside {OPC_SIGNED_SUM_WITH_CARRY, OPC_UNSIGNED_SUM_WITH_CARRY} ? z_m : 1'b1);
        if (ins[ZW_BIT]) z_m = zz;
        if (ins[CW_BIT]) c_m = cc;
        if (ins[RW_BIT]) rf_m[ins[DST_HI:DST_LO]] = r;
        res_m = r;
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge sys_clk_i);
        error_cnt++;
        wrap_up();
    end

    // ==========================================================
    // Main sequence
    initial begin
        logic [31:0] ins, v;
        logic [1:0]  rs;
        logic [8:0]  dst;
        logic [95:0] a96, b96, s96;
        repeat (6) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        @(posedge sys_clk_i);
        `CHK({busy_o, carry_flag_o, zero_flag_o}, 3'h0)
        rd(OFS_FLAGS, v, rs);
        `CHK(v, WORD_RST)
        $display("test reset done");
        for (int i = 0; i < 60; i++) begin
            v = rnd();
            dst = v[8:0];
            ins = {ops[i % 6], v[25:22], 4'hf, dst, v[22] ? v[17:9] : dst ^ 9'h001};
            wr(OFS_FLAGS, {30'h0, v[27:26]}, rs);
            z_m = v[26];
            c_m = v[27];
            put(dst, (i % 3 == 1) ? spec[i % 4] : rnd());
            put(dst ^ 9'h001, (i % 3 == 0) ? spec[(i / 3) % 4] : rnd());
            // Every fourth pass issues back to back, so the second write stalls
            busy_cnt = 0;
            repeat (1 + int'(i % 4 == 0)) begin
                wr(OFS_INSTR, ins, rs);
                model(ins);
            end
            @(posedge sys_clk_i);
            while (busy_o === 1'b1) @(posedge sys_clk_i);
            `CHK(busy_cnt, EXEC_CYCLES * (1 + int'(i % 4 == 0)))
            rd(OFS_FLAGS, v, rs);
            `CHK(v, {30'h0, c_m, z_m})
            `CHK({carry_flag_o, zero_flag_o}, {c_m, z_m})
            rd(OFS_RESULT, v, rs);
            `CHK(v, res_m)
            wr(OFS_RF_INDEX, 32'(dst), rs);
            rd(OFS_RF_DATA, v, rs);
            `CHK(v, rf_m[dst])
        end
        $display("test arithmetic done");
        // Three-word signed add: plain, extended, then signed extended
        for (int k = 0; k < 2; k++) begin
            a96 = {rnd(), rnd(), rnd()};
            b96 = (k == 1) ? -a96 : {rnd(), rnd(), rnd()};
            s96 = a96 + b96;
            for (int w = 0; w < 3; w++) begin
                put(9'(w), a96[w*32 +: 32]);
                put(9'(w + 3), b96[w*32 +: 32]);
            end
            busy_cnt = 0;
            for (int w = 0; w < 3; w++) begin
                ins = {((w == 0) ? OPC_UNSIGNED_SUM : (w == 1) ? OPC_UNSIGNED_SUM_WITH_CARRY
                        : OPC_SIGNED_SUM_WITH_CARRY), 4'he, 4'hf, 9'(w), 9'(w + 3)};
                wr(OFS_INSTR, ins, rs);
                model(ins);
            end
            @(posedge sys_clk_i);
            while (busy_o === 1'b1) @(posedge sys_clk_i);
            `CHK(busy_cnt, 3 * EXEC_CYCLES)
            rd(OFS_FLAGS, v, rs);
            `CHK(v, {30'h0, (a96[95] == b96[95] && s96[95] != a96[95]), (s96 == 96'h0)})
            for (int w = 0; w < 3; w++) begin
                wr(OFS_RF_INDEX, 32'(w), rs);
                rd(OFS_RF_DATA, v, rs);
                `CHK(v, s96[w*32 +: 32])
            end
        end
        $display("test chain done");
        wr(OFS_INSTR, 32'h0, rs);
        rd(OFS_STATUS, v, rs);
        `CHK(v, 32'h2)
        wr(OFS_STATUS, 32'h2, rs);
        rd(OFS_STATUS, v, rs);
        `CHK(v, 32'h0)
        wr(8'h18, 32'h1, rs);
        `CHK(rs, RESP_SLVERR)
        rd(8'hfc, v, rs);
        `CHK({rs, v}, {RESP_SLVERR, WORD_RST})
        put(9'h007, 32'h1111_1111);
        s_axi_wstrb_i <= 4'h3;
        wr(OFS_RF_DATA, 32'ha5a5_a5a5, rs);
        s_axi_wstrb_i <= 4'hf;
        rf_m[7] = 32'h1111_a5a5;
        rd(OFS_RF_DATA, v, rs);
        `CHK(v, rf_m[7])
        wr(OFS_RESULT, 32'h5a, rs);
        rd(OFS_RESULT, v, rs);
        `CHK({rs, v}, {RESP_OKAY, res_m})
        $display("test decode done");
        wrap_up();
    end
endmodule

bind cog_add_abs_alu cog_add_abs_alu_asserts i_chk (.sys_clk_i, .rst_i, .s_axi_awready_o, .s_axi_bresp_o,
    .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o,
    .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .busy_o, .zero_flag_o, .carry_flag_o);
